/* rtl/pdmac_cfg.svh */
// constants of the peripheral dma channel register block
// assumes a 32-bit apb slave with the block decoded on address bits 11:0
`ifndef PDMAC_CFG_SVH
`define PDMAC_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PDMAC_OFF_RXADR 12'h100
`define PDMAC_OFF_RXCNT 12'h104
`define PDMAC_OFF_TXADR 12'h108
`define PDMAC_OFF_TXCNT 12'h10C
`define PDMAC_OFF_RXNADR 12'h110
`define PDMAC_OFF_RXNCNT 12'h114
`define PDMAC_OFF_TXNADR 12'h118
`define PDMAC_OFF_TXNCNT 12'h11C
`define PDMAC_OFF_CTRL 12'h120
`define PDMAC_OFF_STATE 12'h124
`define PDMAC_OFF_UNIT 12'h128
`define PDMAC_OFF_FLAGS 12'h12C
`define PDMAC_OFF_FIRST 12'h100
`define PDMAC_OFF_LAST 12'h12C
// ----------------------------------------
// field positions
// ----------------------------------------
`define PDMAC_BIT_RXEN 0
`define PDMAC_BIT_RXDIS 1
`define PDMAC_BIT_TXEN 8
`define PDMAC_BIT_TXDIS 9
`define PDMAC_BIT_RXEND 0
`define PDMAC_BIT_TXEND 1
`define PDMAC_BIT_RXFULL 2
`define PDMAC_BIT_TXEMPTY 3
`define PDMAC_CNT_W 16
// ----------------------------------------
// unit codes and sizes in bytes
// ----------------------------------------
`define PDMAC_UNIT_BYTE 2'h0
`define PDMAC_UNIT_HALF 2'h1
`define PDMAC_BYTES_1 3'h1
`define PDMAC_BYTES_2 3'h2
`define PDMAC_BYTES_4 3'h4
`define PDMAC_RST_WORD 32'h0000_0000
`endif

/* rtl/pdmac_pkg.sv */
// types shared by the peripheral dma channel block
// assumes pdmac_cfg.svh for widths
`include "pdmac_cfg.svh"
package pdmac_pkg;
    // ----------------------------------------
    // channel pointer and counter set
    // ----------------------------------------
    typedef struct packed {
        logic [31:0] curPtr;
        logic [`PDMAC_CNT_W-1:0] curCnt;
        logic [31:0] nxtPtr;
        logic [`PDMAC_CNT_W-1:0] nxtCnt;
    } pdmac_chan_t;
    typedef struct packed {
        logic ready;
        logic slvErr;
    } pdmac_apb_t;
    typedef enum logic [1:0] {
        PDMAC_IDLE = 2'b00,
        PDMAC_RXWR = 2'b01,
        PDMAC_TXRD = 2'b10
    } pdmac_fsm_t;
    typedef struct packed {
        pdmac_fsm_t fsm;
        logic rxEn;
        logic txEn;
        logic [1:0] unit;
        logic [31:0] prdata;
        logic memReq;
        logic memWe;
        logic [31:0] memAddr;
        logic [31:0] memWdata;
        logic [1:0] memSize;
        logic [31:0] txData;
        logic txLoad;
        logic [3:0] flags;
    } pdmac_state_t;
endpackage : pdmac_pkg

/* rtl/pdmac_apb.sv */
// apb slave timing: one wait state, error on unmapped offsets
// assumes apb master signals on the clk_sys domain
`include "pdmac_cfg.svh"
module pdmac_apb (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    output logic pready,
    output logic pslverr,
    output logic wrStb,
    output logic rdStb
);
    pdmac_pkg::pdmac_apb_t s_q;
    pdmac_pkg::pdmac_apb_t s_d;
    logic hit;
    logic access;

    assign hit = (paddr >= `PDMAC_OFF_FIRST) && (paddr <= `PDMAC_OFF_LAST) && (paddr[1:0] == 2'h0);
    assign access = psel && penable;
    // read data is captured on the same edge that ready rises
    assign rdStb = access && !s_q.ready && !pwrite && hit;
    assign wrStb = access && s_q.ready && pwrite && hit;
    assign pready = s_q.ready;
    assign pslverr = s_q.slvErr;

    always_comb begin
        s_d = s_q;
        s_d.ready = access && !s_q.ready;
        s_d.slvErr = access && !s_q.ready && !hit;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_q <= '0;
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end
endmodule : pdmac_apb

/* rtl/pdmac_chan.sv */
// one pointer and counter set with next-buffer reload
// assumes write strobes and step from the same clock domain
`include "pdmac_cfg.svh"
module pdmac_chan (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic [3:0] wrSel,
    input wire logic [31:0] wdata,
    input wire logic step,
    input wire logic [2:0] unitBytes,
    output pdmac_pkg::pdmac_chan_t chan
);
    pdmac_pkg::pdmac_chan_t c_q;
    pdmac_pkg::pdmac_chan_t c_d;

    assign chan = c_q;

    always_comb begin
        c_d = c_q;
        if (c_q.curCnt == '0 && c_q.nxtCnt != '0) begin
            c_d.curPtr = c_q.nxtPtr;
            c_d.curCnt = c_q.nxtCnt;
            c_d.nxtPtr = '0;
            c_d.nxtCnt = '0;
        end else if (step && c_q.curCnt != '0) begin
            c_d.curCnt = c_q.curCnt - 1'b1;
            c_d.curPtr = c_q.curPtr + {29'h0, unitBytes};
        end
        // software writes win; a moved pointer is simply used from now on
        if (wrSel[0]) c_d.curPtr = wdata;
        if (wrSel[1]) c_d.curCnt = wdata[`PDMAC_CNT_W-1:0];
        if (wrSel[2]) c_d.nxtPtr = wdata;
        if (wrSel[3]) c_d.nxtCnt = wdata[`PDMAC_CNT_W-1:0];
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            c_q <= '0;
        end else if (clkEn) begin
            c_q <= c_d;
        end
    end
endmodule : pdmac_chan

/* rtl/pdmac_top.sv */
// peripheral dma channel pair: registers, enables and transfer engine
// assumes peripheral ready strobes and memory bus on clk_sys
// Operation
// - zero counter stops, nonzero transfers when enabled
// - half duplex shares the current pointer
// - half duplex shares the current counter
// - receive next pointer register, 32 bits
// - receive next counter register, 16 bits
// - transmit next pointer register, 32 bits
// - transmit next counter register, 16 bits
// - half duplex shares next pointer and counter
// - bit 0 enables receive unless bit 1
// - bit 1 disables receive requests
// - bit 8 enables, bit 9 disables transmit
// - half duplex receive enable clears transmit
// - half duplex transmit enable only without receive; code blocks it only when bit 0 is set in the same write
// - half duplex receive disable stops transmit
// - half duplex transmit disable stops receive
// - status bit 0 receive, bit 8 transmit
// - empty current reloads from nonzero next
// - pointer advances by 1, 2 or 4
// - end flags when current counters reach zero
// - buffer flags when current and next zero
//
// The implementer's own choices: the register offsets and the APB slave port.
`include "pdmac_cfg.svh"
module pdmac_top #(
    parameter bit HALF_DUPLEX = 1'b0
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxReady,
    input wire logic [31:0] rxData,
    input wire logic txReady,
    output logic [31:0] txData,
    output logic txLoad,
    output logic rxEndFlag,
    output logic txEndFlag,
    output logic rxBuffersFullFlag,
    output logic txBuffersEmptyFlag,
    output logic memReq,
    output logic memWe,
    output logic [31:0] memAddr,
    output logic [31:0] memWdata,
    output logic [1:0] memSize,
    input wire logic memAck,
    input wire logic [31:0] memRdata
);
    // ----------------------------------------
    // channel sets
    // ----------------------------------------
    localparam int NCH = HALF_DUPLEX ? 1 : 2;
    localparam int TXC = NCH - 1;

    pdmac_pkg::pdmac_state_t s_q;
    pdmac_pkg::pdmac_state_t s_d;
    pdmac_pkg::pdmac_chan_t chanSet [NCH];
    pdmac_pkg::pdmac_chan_t rxView;
    pdmac_pkg::pdmac_chan_t txView;
    logic wrStb;
    logic rdStb;
    logic [3:0] rxWrSel;
    logic [3:0] txWrSel;
    logic rxStep;
    logic txStep;
    logic [2:0] unitBytes;
    logic ctrlWr;
    logic rxSet;
    logic txSet;
    logic rxClr;
    logic txClr;
    logic rxGo;
    logic txGo;
    logic rxZero;
    logic txZero;

    pdmac_apb u_apb (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pready(pready),
        .pslverr(pslverr),
        .wrStb(wrStb),
        .rdStb(rdStb)
    );

    // ----------------------------------------
    // register write decode
    // ----------------------------------------
    always_comb begin
        rxWrSel = 4'h0;
        txWrSel = 4'h0;
        ctrlWr = 1'b0;
        if (wrStb) begin
            case (paddr)
                `PDMAC_OFF_RXADR: rxWrSel[0] = 1'b1;
                `PDMAC_OFF_RXCNT: rxWrSel[1] = 1'b1;
                `PDMAC_OFF_RXNADR: rxWrSel[2] = 1'b1;
                `PDMAC_OFF_RXNCNT: rxWrSel[3] = 1'b1;
                `PDMAC_OFF_TXADR: txWrSel[0] = 1'b1;
                `PDMAC_OFF_TXCNT: txWrSel[1] = 1'b1;
                `PDMAC_OFF_TXNADR: txWrSel[2] = 1'b1;
                `PDMAC_OFF_TXNCNT: txWrSel[3] = 1'b1;
                `PDMAC_OFF_CTRL: ctrlWr = 1'b1;
                default: ctrlWr = 1'b0;
            endcase
        end
    end

    always_comb begin
        case (s_q.unit)
            `PDMAC_UNIT_BYTE: unitBytes = `PDMAC_BYTES_1;
            `PDMAC_UNIT_HALF: unitBytes = `PDMAC_BYTES_2;
            default: unitBytes = `PDMAC_BYTES_4;
        endcase
    end

    // ----------------------------------------
    // one set per direction, or one shared set
    // ----------------------------------------
    // in half duplex both names land on set 0, so either view reads the same
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_chan
            localparam bit IS_RX = (gi == 0);
            localparam bit IS_TX = (gi == TXC);
            logic [3:0] sel;
            logic stepIn;
            assign sel = (IS_RX ? rxWrSel : 4'h0) | (IS_TX ? txWrSel : 4'h0);
            assign stepIn = (IS_RX && rxStep) || (IS_TX && txStep);
            pdmac_chan u_chan (
                .clk_sys(clk_sys),
                .reset_n(reset_n),
                .clkEn(clkEn),
                .wrSel(sel),
                .wdata(pwdata),
                .step(stepIn),
                .unitBytes(unitBytes),
                .chan(chanSet[gi])
            );
        end
    endgenerate

    assign rxView = chanSet[0];
    assign txView = chanSet[TXC];

    // ----------------------------------------
    // enable control
    // ----------------------------------------
    assign rxSet = ctrlWr && pwdata[`PDMAC_BIT_RXEN] && !pwdata[`PDMAC_BIT_RXDIS];
    assign txSet = ctrlWr && pwdata[`PDMAC_BIT_TXEN] && !(HALF_DUPLEX && pwdata[`PDMAC_BIT_RXEN]);
    // half duplex: one disable kills both directions
    assign rxClr = ctrlWr && (pwdata[`PDMAC_BIT_RXDIS] || (HALF_DUPLEX && pwdata[`PDMAC_BIT_TXDIS]));
    assign txClr = ctrlWr && (pwdata[`PDMAC_BIT_TXDIS] || (HALF_DUPLEX && pwdata[`PDMAC_BIT_RXDIS]))
        || (HALF_DUPLEX && rxSet);

    assign rxZero = (rxView.curCnt == '0);
    assign txZero = (txView.curCnt == '0);
    assign rxGo = s_q.rxEn && rxReady && !rxZero;
    assign txGo = s_q.txEn && txReady && !txZero;
    assign rxStep = (s_q.fsm == pdmac_pkg::PDMAC_RXWR) && memAck;
    assign txStep = (s_q.fsm == pdmac_pkg::PDMAC_TXRD) && memAck;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.txLoad = 1'b0;
        // a disable takes priority over an enable in the same write
        s_d.rxEn = (s_q.rxEn || rxSet) && !rxClr;
        s_d.txEn = (s_q.txEn || txSet) && !txClr;
        if (wrStb && paddr == `PDMAC_OFF_UNIT) begin
            s_d.unit = pwdata[1:0];
        end
        if (rdStb) begin
            case (paddr)
                `PDMAC_OFF_RXADR: s_d.prdata = rxView.curPtr;
                `PDMAC_OFF_RXCNT: s_d.prdata = {16'h0, rxView.curCnt};
                `PDMAC_OFF_TXADR: s_d.prdata = txView.curPtr;
                `PDMAC_OFF_TXCNT: s_d.prdata = {16'h0, txView.curCnt};
                `PDMAC_OFF_RXNADR: s_d.prdata = rxView.nxtPtr;
                `PDMAC_OFF_RXNCNT: s_d.prdata = {16'h0, rxView.nxtCnt};
                `PDMAC_OFF_TXNADR: s_d.prdata = txView.nxtPtr;
                `PDMAC_OFF_TXNCNT: s_d.prdata = {16'h0, txView.nxtCnt};
                `PDMAC_OFF_STATE: begin
                    s_d.prdata = `PDMAC_RST_WORD;
                    s_d.prdata[`PDMAC_BIT_RXEN] = s_q.rxEn;
                    s_d.prdata[`PDMAC_BIT_TXEN] = s_q.txEn;
                end
                `PDMAC_OFF_UNIT: s_d.prdata = {30'h0, s_q.unit};
                `PDMAC_OFF_FLAGS: s_d.prdata = {28'h0, s_q.flags};
                default: s_d.prdata = `PDMAC_RST_WORD; // control reads as zero
            endcase
        end
        // ----------------------------------------
        // transfer engine, receive first
        // ----------------------------------------
        case (s_q.fsm)
            pdmac_pkg::PDMAC_IDLE: begin
                if (rxGo) begin
                    s_d.fsm = pdmac_pkg::PDMAC_RXWR;
                    s_d.memReq = 1'b1;
                    s_d.memWe = 1'b1;
                    s_d.memAddr = rxView.curPtr;
                    s_d.memWdata = rxData;
                    s_d.memSize = s_q.unit;
                end else if (txGo) begin
                    s_d.fsm = pdmac_pkg::PDMAC_TXRD;
                    s_d.memReq = 1'b1;
                    s_d.memWe = 1'b0;
                    s_d.memAddr = txView.curPtr;
                    s_d.memSize = s_q.unit;
                end
            end
            pdmac_pkg::PDMAC_RXWR: begin
                // a started unit always completes, even if disabled meanwhile
                if (memAck) begin
                    s_d.fsm = pdmac_pkg::PDMAC_IDLE;
                    s_d.memReq = 1'b0;
                    s_d.memWe = 1'b0;
                end
            end
            pdmac_pkg::PDMAC_TXRD: begin
                if (memAck) begin
                    s_d.fsm = pdmac_pkg::PDMAC_IDLE;
                    s_d.memReq = 1'b0;
                    s_d.txData = memRdata;
                    s_d.txLoad = 1'b1;
                end
            end
            default: begin
                s_d.fsm = pdmac_pkg::PDMAC_IDLE;
                s_d.memReq = 1'b0;
            end
        endcase
        // flags follow counters one cycle late, so the last step is seen
        s_d.flags[`PDMAC_BIT_RXEND] = rxZero;
        s_d.flags[`PDMAC_BIT_TXEND] = txZero;
        s_d.flags[`PDMAC_BIT_RXFULL] = rxZero && (rxView.nxtCnt == '0);
        s_d.flags[`PDMAC_BIT_TXEMPTY] = txZero && (txView.nxtCnt == '0);
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_q <= '0;
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign prdata = s_q.prdata;
    assign txData = s_q.txData;
    assign txLoad = s_q.txLoad;
    assign rxEndFlag = s_q.flags[`PDMAC_BIT_RXEND];
    assign txEndFlag = s_q.flags[`PDMAC_BIT_TXEND];
    assign rxBuffersFullFlag = s_q.flags[`PDMAC_BIT_RXFULL];
    assign txBuffersEmptyFlag = s_q.flags[`PDMAC_BIT_TXEMPTY];
    assign memReq = s_q.memReq;
    assign memWe = s_q.memWe;
    assign memAddr = s_q.memAddr;
    assign memWdata = s_q.memWdata;
    assign memSize = s_q.memSize;
endmodule : pdmac_top

/* verification/pdmac_chk.sv */
// port timing checker for pdmac_top
// assumes one clk_sys domain, synchronous active-low reset
module pdmac_chk (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxReady,
    input wire logic [31:0] rxData,
    input wire logic txReady,
    input wire logic [31:0] txData,
    input wire logic txLoad,
    input wire logic txBuffersEmptyFlag,
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [31:0] memAddr,
    input wire logic [31:0] memWdata,
    input wire logic memAck,
    input wire logic [31:0] memRdata
);
    // --------
    // assertions
    // --------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    req_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe))
        else $error("memory request not held");
    req_drop_a: assert property (memReq && memAck |=> !memReq)
        else $error("memory request kept after ack");
    load_data_a: assert property (memReq && memAck && !memWe |=> txLoad && txData == $past(memRdata))
        else $error("transmit data not loaded");
    load_cause_a: assert property (txLoad |-> $past(memReq && memAck && !memWe))
        else $error("txLoad without memory read");
    rx_start_a: assert property ($rose(memReq) && memWe |-> $past(rxReady) && memWdata == $past(rxData))
        else $error("receive unit without ready");
    tx_start_a: assert property ($rose(memReq) && !memWe |-> $past(txReady))
        else $error("transmit unit without ready");
    reset_out_a: assert property ($rose(reset_n) |-> !memReq && !txLoad && !pready ##1 txBuffersEmptyFlag)
        else $error("outputs wrong after reset");
    cover property (txLoad);
    cover property ($rose(memReq) && memWe);
    cover property (pready && pslverr);
endmodule : pdmac_chk
bind pdmac_top pdmac_chk pdmac_chk_inst (
    .clk_sys, .reset_n, .psel, .penable, .pready, .pslverr, .rxReady, .rxData, .txReady, .txData,
    .txLoad, .txBuffersEmptyFlag, .memReq, .memWe, .memAddr, .memWdata, .memAck, .memRdata
);

/* verification/pdmac_mem.sv */
// memory side model for the pdmac memory port
// assumes one-cycle memAck pulses on clk_sys
module pdmac_mem (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic memReq,
    input wire logic [31:0] memAddr,
    input wire logic [31:0] memWdata,
    output logic memAck,
    output logic [31:0] memRdata,
    output int ackCnt,
    output logic [31:0] lastAddr,
    output logic [31:0] lastWdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] waitQ;
    logic [31:0] noise;
    // read data only means something with the ack, so it churns otherwise
    assign memRdata = memAck ? (lastAddr ^ 32'h5A5A_0000) : noise;
    always @(posedge clk_sys) begin
        noise <= {noise[30:0], ~noise[31]};
        memAck <= 1'b0;
        if (!reset_n) begin
            waitQ <= 2'h0;
            ackCnt <= 0;
            noise <= 32'h1357_9BDF;
        end else if (memReq && !memAck) begin
            if (waitQ == (slow ? 2'h3 : 2'h0)) begin
                memAck <= 1'b1;
                waitQ <= 2'h0;
                ackCnt <= ackCnt + 1;
                lastAddr <= memAddr;
                lastWdata <= memWdata;
            end else begin
                waitQ <= waitQ + 2'h1;
            end
        end
    end
endmodule : pdmac_mem

/* verification/pdmac_top_tb.sv */
// self-checking bench for pdmac_top built half duplex
// assumes pdmac_mem answers the memory port
`include "pdmac_cfg.svh"
module pdmac_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, reset_n = 1'b0, clkEn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic rxReady = 1'b0, txReady = 1'b0, slow = 1'b0, pready, pslverr, txLoad, memReq, memWe, memAck;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rxData = 32'h0, prdata, txData, memAddr, memWdata, memRdata, lastAddr, lastWdata;
    logic rxEndFlag, txEndFlag, rxBuffersFullFlag, txBuffersEmptyFlag;
    logic [1:0] memSize;
    logic [31:0] loadData [8];
    int ackCnt, loadCnt = 0, err_total = 0, n_tests = 0;
    pdmac_top #(.HALF_DUPLEX(1'b1)) pdmac_top_inst (
        .clk_sys, .reset_n, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .rxReady, .rxData, .txReady, .txData, .txLoad, .rxEndFlag, .txEndFlag, .rxBuffersFullFlag,
        .txBuffersEmptyFlag, .memReq, .memWe, .memAddr, .memWdata, .memSize, .memAck, .memRdata
    );
    pdmac_mem pdmac_mem_inst (
        .clk_sys, .reset_n, .slow, .memReq, .memAddr, .memWdata, .memAck, .memRdata, .ackCnt, .lastAddr, .lastWdata
    );
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (txLoad === 1'b1) begin
            loadData[loadCnt % 8] <= txData;
            loadCnt <= loadCnt + 1;
        end
    end
    // --------
    // shared tasks
    // --------
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic rw(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e, input logic er);
        int k;
        k = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        check($sformatf("answer %h", a), {30'h0, pready, pslverr}, {30'h0, 1'b1, er});
        if (!wr) check($sformatf("rdata %h", a), prdata, e);
    endtask : rw
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // --------
    // scenarios
    // --------
    task automatic t_reset;
        for (int i = 0; i < 8; i++) rw(1'b0, 12'(`PDMAC_OFF_FIRST + 4 * i), 32'h0, 32'h0, 1'b0);
        rw(1'b0, `PDMAC_OFF_STATE, 32'h0, 32'h0, 1'b0);
        rw(1'b0, `PDMAC_OFF_FLAGS, 32'h0, 32'h0000_000F, 1'b0);
        // unmapped read keeps the previous read data
        rw(1'b0, 12'h130, 32'h0, 32'h0000_000F, 1'b1);
        rw(1'b1, 12'h102, 32'h1, 32'h0, 1'b1);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_alias;
        rw(1'b1, `PDMAC_OFF_TXADR, 32'h1234_5678, 32'h0, 1'b0);
        rw(1'b0, `PDMAC_OFF_RXADR, 32'h0, 32'h1234_5678, 1'b0);
        rw(1'b1, `PDMAC_OFF_RXCNT, 32'hABCD_0007, 32'h0, 1'b0);
        rw(1'b0, `PDMAC_OFF_TXCNT, 32'h0, 32'h0000_0007, 1'b0);
        rw(1'b1, `PDMAC_OFF_RXNADR, 32'h8765_4321, 32'h0, 1'b0);
        rw(1'b0, `PDMAC_OFF_TXNADR, 32'h0, 32'h8765_4321, 1'b0);
        rw(1'b1, `PDMAC_OFF_TXNCNT, 32'h0001_FFFF, 32'h0, 1'b0);
        rw(1'b0, `PDMAC_OFF_RXNCNT, 32'h0, 32'h0000_FFFF, 1'b0);
        rw(1'b0, `PDMAC_OFF_FLAGS, 32'h0, 32'h0, 1'b0);
        check("flag pins", {28'h0, txBuffersEmptyFlag, rxBuffersFullFlag, txEndFlag, rxEndFlag}, 32'h0);
        // next count cleared first, or an empty current set would reload from it
        rw(1'b1, `PDMAC_OFF_TXNCNT, 32'h0, 32'h0, 1'b0);
        rw(1'b1, `PDMAC_OFF_TXCNT, 32'h0, 32'h0, 1'b0);
        $display("t_alias done");
    endtask : t_alias
    task automatic t_ctrl;
        logic [31:0] tbl [13] = '{32'h0100_0100, 32'h0001_0001, 32'h0200_0000, 32'h0001_0001, 32'h0000_0001,
            32'h0002_0000, 32'h0100_0100, 32'h0002_0000, 32'h0001_0001, 32'h0100_0101, 32'h0003_0000,
            32'h0100_0100, 32'h0300_0000};
        for (int i = 0; i < 13; i++) begin
            rw(1'b1, `PDMAC_OFF_CTRL, {16'h0, tbl[i][31:16]}, 32'h0, 1'b0);
            rw(1'b0, `PDMAC_OFF_STATE, 32'h0, {16'h0, tbl[i][15:0]}, 1'b0);
        end
        rw(1'b0, `PDMAC_OFF_CTRL, 32'h0, 32'h0, 1'b0);
        rw(1'b1, `PDMAC_OFF_STATE, 32'h0000_0101, 32'h0, 1'b0);
        rw(1'b0, `PDMAC_OFF_STATE, 32'h0, 32'h0, 1'b0);
        $display("t_ctrl done");
    endtask : t_ctrl
    task automatic t_tx;
        int base, k;
        logic [31:0] adr [3] = '{32'h0000_2000, 32'h0000_2002, 32'h0000_3000};
        base = loadCnt;
        slow <= 1'b1;
        rw(1'b1, `PDMAC_OFF_CTRL, 32'h0000_0100, 32'h0, 1'b0);
        txReady <= 1'b1;
        repeat (10) @(posedge clk_sys);
        check("idle acks", 32'(ackCnt), 32'h0);
        txReady <= 1'b0;
        rw(1'b1, `PDMAC_OFF_UNIT, 32'h0000_0001, 32'h0, 1'b0);
        rw(1'b1, `PDMAC_OFF_TXADR, adr[0], 32'h0, 1'b0);
        rw(1'b1, `PDMAC_OFF_TXCNT, 32'h0000_0002, 32'h0, 1'b0);
        rw(1'b1, `PDMAC_OFF_TXNADR, adr[2], 32'h0, 1'b0);
        rw(1'b1, `PDMAC_OFF_TXNCNT, 32'h0000_0001, 32'h0, 1'b0);
        // a low clock enable must hold the engine idle despite a ready peer
        clkEn <= 1'b0;
        txReady <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check("frozen acks", 32'(ackCnt), 32'h0);
        clkEn <= 1'b1;
        k = 0;
        while (loadCnt < base + 3 && k < 300) begin
            @(posedge clk_sys);
            k++;
        end
        repeat (12) @(posedge clk_sys);
        txReady <= 1'b0;
        check("loads", 32'(loadCnt - base), 32'h3);
        for (int j = 0; j < 3; j++) check("txData", loadData[(base + j) % 8], adr[j] ^ 32'h5A5A_0000);
        rw(1'b0, `PDMAC_OFF_TXADR, 32'h0, 32'h0000_3002, 1'b0);
        rw(1'b0, `PDMAC_OFF_TXNADR, 32'h0, 32'h0, 1'b0);
        rw(1'b0, `PDMAC_OFF_TXNCNT, 32'h0, 32'h0, 1'b0);
        rw(1'b0, `PDMAC_OFF_FLAGS, 32'h0, 32'h0000_000F, 1'b0);
        check("flag pins", {28'h0, txBuffersEmptyFlag, rxBuffersFullFlag, txEndFlag, rxEndFlag}, 32'hF);
        rw(1'b1, `PDMAC_OFF_CTRL, 32'h0000_0200, 32'h0, 1'b0);
        $display("t_tx done");
    endtask : t_tx
    task automatic t_rx(input logic [1:0] u, input logic [31:0] step);
        int base, k;
        logic [1:0] sz;
        base = ackCnt;
        sz = 2'h3;
        slow <= 1'b0;
        rxData <= 32'hC0DE_0000 | step;
        rw(1'b1, `PDMAC_OFF_UNIT, {30'h0, u}, 32'h0, 1'b0);
        rw(1'b1, `PDMAC_OFF_RXADR, 32'h0000_4000, 32'h0, 1'b0);
        rw(1'b1, `PDMAC_OFF_RXCNT, 32'h0000_0003, 32'h0, 1'b0);
        rw(1'b1, `PDMAC_OFF_CTRL, 32'h0000_0001, 32'h0, 1'b0);
        rxReady <= 1'b1;
        k = 0;
        while (ackCnt < base + 3 && k < 100) begin
            @(posedge clk_sys);
            if (memReq === 1'b1) sz = memSize;
            k++;
        end
        repeat (8) @(posedge clk_sys);
        rxReady <= 1'b0;
        check("acks", 32'(ackCnt - base), 32'h3);
        check("size", {30'h0, sz}, {30'h0, u});
        check("last addr", lastAddr, 32'h0000_4000 + 2 * step);
        check("last data", lastWdata, 32'hC0DE_0000 | step);
        rw(1'b0, `PDMAC_OFF_RXADR, 32'h0, 32'h0000_4000 + 3 * step, 1'b0);
        rw(1'b0, `PDMAC_OFF_FLAGS, 32'h0, 32'h0000_000F, 1'b0);
        rw(1'b1, `PDMAC_OFF_CTRL, 32'h0000_0002, 32'h0, 1'b0);
        $display("t_rx done");
    endtask : t_rx
    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset();
        t_alias();
        t_ctrl();
        t_tx();
        t_rx(2'h0, 32'h1);
        t_rx(2'h2, 32'h4);
        t_rx(2'h3, 32'h4);
        // second reset after traffic must clear everything again
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset();
        report_and_stop();
    end
    initial begin
        #400000;
        err_total++;
        report_and_stop();
    end
endmodule : pdmac_top_tb
